// File: mar_ctrl.sv
// Ack request marking, ack wait, retransmission and ack generation.
// Assumes framer, PHY side and Wishbone master all run on clk_in.
//
// Overview of operation
// - Beacon and ack frames always go out with ack request clear.
// - Broadcast frames go out with ack request clear.
// - No ack for frames without ack request; sender reports success.
// - Ack for a good frame carries that frame's sequence number.
// - Outside contention period, ack starts exactly one turnaround after frame end.
// - In contention period, ack starts at a slot bound after turnaround, or at turnaround plus one backoff.
// - Sender waits at most the ack wait limit for the ack.
// - Matching ack in time means success, no more retries.
// - Timeout or wrong sequence number fails the attempt.
// - Failed indirect frame stays queued until a new data request.
// - Queued frame resent with its original sequence number.
// - Failed direct frame retried up to retry limit, same sequence.
// - Retry starts only if it fits the current superframe portion.
// - After one plus retry limit failures, failure is reported.
// - Ack wait timer starts at send end, stops on matching ack.
// - Acknowledged transfer reports success upward.
// - Queued frame dropped with failure once its lifetime ends.
`timescale 1ns/100ps
module mar_ctrl
    import mar_pkg::*;
#(
    parameter int OCLK_DIV     = MAR_OCLK_DIV,
    parameter int TURN_OCLK    = MAR_TURN_OCLK,
    parameter int BACKOFF_OCLK = MAR_BACKOFF_OCLK
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic             irq_out,
    // Frame request from higher layer
    input  wire logic        req_valid_in,
    input  wire logic [1:0]  req_type_in,
    input  wire logic [7:0]  req_seq_in,
    input  wire logic        req_ack_in,
    input  wire logic        req_bcast_in,
    input  wire logic        req_indirect_in,
    output logic             req_ready_out,
    // Superframe and queue events
    input  wire logic        fit_in,
    input  wire logic        slot_bound_in,
    input  wire logic        data_req_in,
    // Received frame summary
    input  wire logic        rx_end_in,
    input  wire logic [1:0]  rx_type_in,
    input  wire logic [7:0]  rx_seq_in,
    input  wire logic        rx_ack_req_in,
    input  wire logic        rx_bcast_in,
    // Transmit to framer
    output logic             tx_start_out,
    output logic      [1:0]  tx_type_out,
    output logic      [7:0]  tx_seq_out,
    output logic             tx_ack_req_out,
    output logic             tx_bcast_out,
    input  wire logic        tx_done_in,
    // Confirmation to higher layer
    output logic             conf_valid_out,
    output logic             conf_ok_out,
    output logic      [7:0]  conf_seq_out
);

    localparam logic [MAR_CNT_W-1:0] TURN_CNT = MAR_CNT_W'(TURN_OCLK);
    localparam logic [MAR_CNT_W-1:0] TURN_END = MAR_CNT_W'(TURN_OCLK + BACKOFF_OCLK);

    logic [31:0]          cfg_reg;
    logic [31:0]          wait_reg;
    logic [31:0]          life_reg;
    logic [MAR_ST_W-1:0]  stat_reg;
    logic [MAR_ST_W-1:0]  mask_reg;
    logic [MAR_ST_W-1:0]  stat_set;
    logic [31:0]          rd_data;
    logic [31:0]          wmask;
    mar_ost_t             ost_reg;
    logic [7:0]           seq_reg;
    logic [1:0]           type_reg;
    logic                 areq_reg;
    logic                 bcast_reg;
    logic                 ind_reg;
    logic                 gone_reg;
    logic [MAR_RETRY_W-1:0] retry_reg;
    logic                 ack_pend_reg;
    logic [7:0]           ack_seq_reg;
    logic                 tx_busy_reg;
    logic                 tick;
    logic [MAR_CNT_W-1:0] wait_cnt;
    logic [MAR_CNT_W-1:0] life_cnt;
    logic [MAR_CNT_W-1:0] turn_cnt;
    logic                 wait_exp;
    logic                 life_exp;
    logic                 turn_exp;
    logic                 bus_req;
    logic                 bus_wr;
    logic                 rd_clr;
    logic                 accept;
    logic                 areq_calc;
    logic                 ack_rx;
    logic                 att_ok;
    logic                 att_fail;
    logic                 fin_ok;
    logic                 fin_fail;
    logic                 orig_go;
    logic                 ack_go;
    logic                 rx_ack_need;
    logic                 cont_mode;
    logic [MAR_RETRY_W-1:0] retry_lim;

    assign retry_lim = cfg_reg[MAR_RETRY_LSB +: MAR_RETRY_W];
    assign cont_mode = (cfg_reg[MAR_MODE_LSB +: MAR_MODE_W] == MAR_MD_CONT);

    // Optical clock and the three interval timers
    mar_tick_div #(.DIV(OCLK_DIV)) u_div (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .tick_out (tick)
    );

    mar_timer #(.W(MAR_CNT_W)) u_wait (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .tick_in    (tick),
        .start_in   (ost_reg == O_BUSY && tx_done_in && areq_reg),
        .stop_in    (att_ok),
        .limit_in   (wait_reg[MAR_CNT_W-1:0]),
        .count_out  (wait_cnt),
        .expire_out (wait_exp)
    );

    mar_timer #(.W(MAR_CNT_W)) u_life (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .tick_in    (tick),
        .start_in   (accept && req_indirect_in),
        .stop_in    (fin_ok || fin_fail),
        .limit_in   (life_reg[MAR_CNT_W-1:0]),
        .count_out  (life_cnt),
        .expire_out (life_exp)
    );

    mar_timer #(.W(MAR_CNT_W)) u_turn (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .tick_in    (tick),
        .start_in   (rx_ack_need),
        .stop_in    (ack_go),
        .limit_in   (TURN_END),
        .count_out  (turn_cnt),
        .expire_out (turn_exp)
    );

    // Originator decisions
    always_comb begin
        accept  = req_valid_in && req_ready_out;
        areq_calc = req_ack_in && !req_bcast_in &&
                  (req_type_in == MAR_FT_DATA || req_type_in == MAR_FT_CMD);
        ack_rx  = rx_end_in && (rx_type_in == MAR_FT_ACK);
        att_ok  = (ost_reg == O_WAIT) && ack_rx && (rx_seq_in == seq_reg);
        att_fail = (ost_reg == O_WAIT) && !att_ok &&
                   (wait_exp || ack_rx);
        fin_ok  = att_ok || (ost_reg == O_BUSY && tx_done_in && !areq_reg);
        fin_fail = (att_fail && !ind_reg && retry_reg == retry_lim) ||
                   (ost_reg == O_HOLD && (gone_reg || life_exp));
        orig_go = (ost_reg == O_SEND) && !tx_busy_reg && !ack_pend_reg;
    end

    // Recipient decisions
    always_comb begin
        rx_ack_need = rx_end_in && rx_ack_req_in && !rx_bcast_in &&
                      (rx_type_in == MAR_FT_DATA || rx_type_in == MAR_FT_CMD);
        if (cont_mode) begin
            ack_go = ack_pend_reg && !tx_busy_reg && turn_cnt >= TURN_CNT &&
                     (slot_bound_in || turn_cnt >= TURN_END);
        end else begin
            ack_go = ack_pend_reg && !tx_busy_reg && turn_cnt >= TURN_CNT;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_pend_reg <= 1'b0;
            ack_seq_reg  <= 8'h00;
        end else if (rx_ack_need) begin
            ack_pend_reg <= 1'b1;
            ack_seq_reg  <= rx_seq_in;
        end else if (ack_go) begin
            ack_pend_reg <= 1'b0;
        end
    end

    // Originator state machine
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ost_reg        <= O_IDLE;
            seq_reg        <= 8'h00;
            type_reg       <= MAR_FT_DATA;
            areq_reg       <= 1'b0;
            bcast_reg      <= 1'b0;
            ind_reg        <= 1'b0;
            gone_reg       <= 1'b0;
            retry_reg      <= '0;
            conf_valid_out <= 1'b0;
            conf_ok_out    <= 1'b0;
            conf_seq_out   <= 8'h00;
        end else begin
            conf_valid_out <= fin_ok || fin_fail;
            if (fin_ok || fin_fail) begin
                conf_ok_out  <= fin_ok;
                conf_seq_out <= seq_reg;
            end
            if (life_exp) begin
                gone_reg <= 1'b1;
            end
            case (ost_reg)
                O_IDLE: begin
                    if (accept) begin
                        seq_reg   <= req_seq_in;
                        type_reg  <= req_type_in;
                        areq_reg  <= areq_calc;
                        bcast_reg <= req_bcast_in;
                        ind_reg   <= req_indirect_in;
                        gone_reg  <= 1'b0;
                        retry_reg <= '0;
                        ost_reg   <= req_indirect_in ? O_HOLD : O_SEND;
                    end
                end
                O_SEND: begin
                    if (orig_go) begin
                        ost_reg <= O_BUSY;
                    end
                end
                O_BUSY: begin
                    if (tx_done_in) begin
                        ost_reg <= areq_reg ? O_WAIT : O_IDLE;
                    end
                end
                O_WAIT: begin
                    if (fin_ok || fin_fail) begin
                        ost_reg <= O_IDLE;
                    end else if (att_fail && ind_reg) begin
                        ost_reg <= O_HOLD;
                    end else if (att_fail) begin
                        retry_reg <= retry_reg + 1'b1;
                        ost_reg   <= O_DEFER;
                    end
                end
                O_DEFER: begin
                    if (fit_in) begin
                        ost_reg <= O_SEND;
                    end
                end
                O_HOLD: begin
                    if (fin_fail) begin
                        ost_reg <= O_IDLE;
                    end else if (data_req_in) begin
                        ost_reg <= O_SEND;
                    end
                end
                default: begin
                    ost_reg <= O_IDLE;
                end
            endcase
        end
    end

    // Ready follows idle one cycle late and drops on the take
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_ready_out <= 1'b0;
        end else begin
            req_ready_out <= (ost_reg == O_IDLE) && !accept;
        end
    end

    // Transmit port, ack first so turnaround timing is kept
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_start_out   <= 1'b0;
            tx_type_out    <= MAR_FT_DATA;
            tx_seq_out     <= 8'h00;
            tx_ack_req_out <= 1'b0;
            tx_bcast_out   <= 1'b0;
            tx_busy_reg    <= 1'b0;
        end else begin
            tx_start_out <= ack_go || orig_go;
            if (ack_go) begin
                tx_type_out    <= MAR_FT_ACK;
                tx_seq_out     <= ack_seq_reg;
                tx_ack_req_out <= 1'b0;
                tx_bcast_out   <= 1'b0;
                tx_busy_reg    <= 1'b1;
            end else if (orig_go) begin
                tx_type_out    <= type_reg;
                tx_seq_out     <= seq_reg;
                tx_ack_req_out <= areq_reg;
                tx_bcast_out   <= bcast_reg;
                tx_busy_reg    <= 1'b1;
            end else if (tx_done_in) begin
                tx_busy_reg    <= 1'b0;
            end
        end
    end

    // Wishbone slave: one wait state, write and read-clear on the acked edge
    assign bus_req = wb_cyc_in && wb_stb_in;
    assign bus_wr  = bus_req && wb_we_in && wb_ack_out;
    assign rd_clr  = bus_req && !wb_we_in && wb_ack_out && wb_adr_in == MAR_STAT_OFS;
    assign wmask   = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                      {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_adr_in)
            MAR_CFG_OFS:   rd_data = cfg_reg;
            MAR_WAIT_OFS:  rd_data = wait_reg;
            MAR_LIFE_OFS:  rd_data = life_reg;
            MAR_STAT_OFS:  rd_data[MAR_ST_W-1:0] = stat_reg;
            MAR_MASK_OFS:  rd_data[MAR_ST_W-1:0] = mask_reg;
            MAR_STATE_OFS: begin
                rd_data[MAR_SR_SEQ_LSB +: 8]             = seq_reg;
                rd_data[MAR_SR_OST_LSB +: 3]             = ost_reg;
                rd_data[MAR_SR_RETRY_LSB +: MAR_RETRY_W] = retry_reg;
                rd_data[MAR_SR_PEND_BIT]                 = ack_pend_reg;
                rd_data[MAR_SR_BUSY_BIT]                 = tx_busy_reg;
            end
            default:       rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= bus_req && !wb_ack_out;
            if (bus_req && !wb_ack_out && !wb_we_in) begin
                wb_dat_out <= rd_data;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_reg  <= MAR_CFG_RST;
            wait_reg <= MAR_WAIT_RST;
            life_reg <= MAR_LIFE_RST;
            mask_reg <= '0;
        end else if (bus_wr) begin
            case (wb_adr_in)
                MAR_CFG_OFS:  cfg_reg  <= (cfg_reg & ~wmask) | (wb_dat_in & wmask);
                MAR_WAIT_OFS: wait_reg <= (wait_reg & ~wmask) | (wb_dat_in & wmask);
                MAR_LIFE_OFS: life_reg <= (life_reg & ~wmask) | (wb_dat_in & wmask);
                MAR_MASK_OFS: begin
                    if (wb_sel_in[0]) begin
                        mask_reg <= wb_dat_in[MAR_ST_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky status; only bits returned by the read are cleared
    always_comb begin
        stat_set              = '0;
        stat_set[MAR_ST_OK]   = conf_valid_out && conf_ok_out;
        stat_set[MAR_ST_FAIL] = conf_valid_out && !conf_ok_out;
        stat_set[MAR_ST_ACK]  = tx_start_out && tx_type_out == MAR_FT_ACK;
        stat_set[MAR_ST_LIFE] = life_exp;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stat_reg <= '0;
            irq_out  <= 1'b0;
        end else begin
            if (rd_clr) begin
                stat_reg <= (stat_reg & ~wb_dat_out[MAR_ST_W-1:0]) | stat_set;
            end else begin
                stat_reg <= stat_reg | stat_set;
            end
            irq_out <= |(stat_reg & mask_reg);
        end
    end

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    ack_ar_clear_a: assert property (
        tx_start_out && (tx_type_out == MAR_FT_ACK || tx_type_out == MAR_FT_BEACON)
        |-> !tx_ack_req_out) else $error("ack request set on beacon or ack");
    bcast_ar_clear_a: assert property (
        tx_start_out && tx_bcast_out |-> !tx_ack_req_out)
        else $error("ack request set on broadcast");
    no_areq_ok_a: assert property (
        ost_reg == O_BUSY && tx_done_in && !areq_reg
        |=> conf_valid_out && conf_ok_out ##1 ost_reg == O_IDLE)
        else $error("frame without ack request not confirmed");
    turn_exact_a: assert property (
        ack_go && !cont_mode && !$past(tx_busy_reg) |-> turn_cnt == TURN_CNT)
        else $error("ack not at turnaround");
    cont_window_a: assert property (
        ack_go && cont_mode |-> turn_cnt >= TURN_CNT && turn_cnt <= TURN_END)
        else $error("ack outside backoff window");
    wait_bound_a: assert property (
        ost_reg == O_WAIT |-> wait_cnt <= wait_reg[MAR_CNT_W-1:0])
        else $error("ack wait overran limit");
    retry_seq_a: assert property (
        orig_go |=> tx_start_out && tx_seq_out == seq_reg && retry_reg <= retry_lim)
        else $error("retransmission sequence or count wrong");
    fail_conf_a: assert property (
        att_fail && !ind_reg && retry_reg == retry_lim
        |=> conf_valid_out && !conf_ok_out)
        else $error("retry exhaustion not reported");
    match_ok_a: assert property (
        att_ok |=> conf_valid_out && conf_ok_out && ost_reg == O_IDLE)
        else $error("matching ack not taken as success");

    retry_c: cover property (att_fail && !ind_reg ##[1:200] att_ok);
    ack_sent_c: cover property (rx_ack_need ##[1:400] ack_go);
    drop_c: cover property (ost_reg == O_HOLD && life_exp);

endmodule

// File: mar_pkg.sv
// Shared constants for the ack and retransmission control block.
// Assumes a 32-bit Wishbone register bus and one clock domain.
package mar_pkg;

    // Register byte offsets
    localparam logic [7:0] MAR_CFG_OFS   = 8'h00;
    localparam logic [7:0] MAR_WAIT_OFS  = 8'h04;
    localparam logic [7:0] MAR_LIFE_OFS  = 8'h08;
    localparam logic [7:0] MAR_STAT_OFS  = 8'h0C;
    localparam logic [7:0] MAR_MASK_OFS  = 8'h10;
    localparam logic [7:0] MAR_STATE_OFS = 8'h14;

    // Configuration fields
    localparam int MAR_RETRY_LSB = 0;
    localparam int MAR_RETRY_W   = 3;
    localparam int MAR_MODE_LSB  = 4;
    localparam int MAR_MODE_W    = 2;

    // Reset values
    localparam logic [31:0] MAR_CFG_RST  = 32'h0000_0003;
    localparam logic [31:0] MAR_WAIT_RST = 32'h0000_0040;
    localparam logic [31:0] MAR_LIFE_RST = 32'h0000_1000;

    // Status and mask bits
    localparam int MAR_ST_OK   = 0;
    localparam int MAR_ST_FAIL = 1;
    localparam int MAR_ST_ACK  = 2;
    localparam int MAR_ST_LIFE = 3;
    localparam int MAR_ST_W    = 4;

    // State readback fields
    localparam int MAR_SR_SEQ_LSB   = 0;
    localparam int MAR_SR_OST_LSB   = 8;
    localparam int MAR_SR_RETRY_LSB = 12;
    localparam int MAR_SR_PEND_BIT  = 16;
    localparam int MAR_SR_BUSY_BIT  = 17;

    // Timing, in optical clocks, and the optical clock divider
    localparam int MAR_TURN_OCLK    = 12;
    localparam int MAR_BACKOFF_OCLK = 20;
    localparam int MAR_OCLK_DIV     = 4;
    localparam int MAR_CNT_W        = 16;

    typedef enum logic [1:0] {
        MAR_FT_BEACON = 2'b00,
        MAR_FT_DATA   = 2'b01,
        MAR_FT_ACK    = 2'b10,
        MAR_FT_CMD    = 2'b11
    } mar_ftype_t;

    typedef enum logic [1:0] {
        MAR_MD_NOBEACON = 2'b00,
        MAR_MD_CONT     = 2'b01,
        MAR_MD_FREE     = 2'b10
    } mar_mode_t;

    typedef enum logic [2:0] {
        O_IDLE  = 3'b000,
        O_SEND  = 3'b001,
        O_BUSY  = 3'b010,
        O_WAIT  = 3'b011,
        O_DEFER = 3'b100,
        O_HOLD  = 3'b101
    } mar_ost_t;

endpackage

// File: mar_tick_div.sv
// Optical clock enable divider.
// Assumes DIV of at least 1; the tick is one clk_in cycle wide.
`timescale 1ns/100ps
module mar_tick_div
    import mar_pkg::*;
#(
    parameter int DIV = MAR_OCLK_DIV
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Enable pulse
    output logic      tick_out
);

    logic [15:0] cnt_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg  <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_reg == 16'(DIV - 1));
            if (cnt_reg == 16'(DIV - 1)) begin
                cnt_reg <= 16'h0000;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

endmodule

// File: mar_timer.sv
// Optical clock interval timer with restart, stop and expiry pulse.
// Assumes tick_in is the optical clock enable; count holds at limit.
`timescale 1ns/100ps
module mar_timer #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    // Control
    input  wire logic         tick_in,
    input  wire logic         start_in,
    input  wire logic         stop_in,
    input  wire logic [W-1:0] limit_in,
    // State
    output logic      [W-1:0] count_out,
    output logic              expire_out
);

    logic         run_reg;
    logic [W-1:0] cnt_next;

    assign cnt_next = count_out + W'(1);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_out  <= '0;
            run_reg    <= 1'b0;
            expire_out <= 1'b0;
        end else begin
            expire_out <= 1'b0;
            if (start_in) begin
                count_out <= '0;
                run_reg   <= 1'b1;
            end else if (stop_in) begin
                count_out <= '0;
                run_reg   <= 1'b0;
            end else if (run_reg && tick_in) begin
                count_out <= cnt_next;
                if (cnt_next >= limit_in) begin
                    run_reg    <= 1'b0;
                    expire_out <= 1'b1;
                end
            end
        end
    end

endmodule

// File: mar_peer.sv
// Peer model: the framer and the remote MAC facing mar_ctrl.
// Assumes one clk_in domain; acks only frames that ask for one.
`timescale 1ns/100ps
module mar_peer
    import mar_pkg::*;
(
    // Clock
    input  wire logic       clk_in,
    // From block and bench
    input  wire logic       tx_start_in,
    input  wire logic [7:0] tx_seq_in,
    input  wire logic       tx_ack_req_in,
    input  wire logic       ack_en_in,
    input  wire logic       rx_go_in,
    input  wire logic [7:0] rx_go_seq_in,
    // To block
    output logic            tx_done_out = 1'b0,
    output logic            rx_end_out = 1'b0,
    output logic      [1:0] rx_type_out,
    output logic      [7:0] rx_seq_out = 8'h00,
    output logic            rx_ack_req_out,
    output logic            rx_bcast_out
);
    logic [3:0] t_reg = 4'h0;
    logic [7:0] sq_reg;
    logic       areq_reg = 1'b0;
    always @(posedge clk_in) begin
        t_reg <= tx_start_in ? 4'h1 : t_reg + {3'h0, t_reg != 4'h0};
        if (tx_start_in) begin
            sq_reg <= tx_seq_in;
            areq_reg <= tx_ack_req_in & ack_en_in;
        end
        tx_done_out <= t_reg == 4'h3;
        rx_end_out <= (t_reg == 4'h8 && areq_reg) || rx_go_in;
        rx_type_out <= rx_go_in ? MAR_FT_DATA : MAR_FT_ACK;
        // Idle sequence flips so a stale value never looks valid
        rx_seq_out <= rx_go_in ? rx_go_seq_in : (t_reg == 4'h8 ? sq_reg : ~rx_seq_out);
        rx_ack_req_out <= rx_go_in;
        rx_bcast_out <= 1'b0;
    end
endmodule

// File: mar_ctrl_tb.sv
// Self-checking bench for mar_ctrl.
// Assumes mar_peer stands in for the framer and the remote MAC.
`timescale 1ns/100ps
module mar_ctrl_tb;
    import mar_pkg::*;
    logic        clk_in = 1'b0, rst_in = 1'b1, cyc = 1'b0, we = 1'b0;
    logic        rv = 1'b0, ra = 1'b0, rb = 1'b0, ack_en = 1'b0, go = 1'b0, ind = 1'b0, dr = 1'b0;
    logic [7:0]  adr = 8'h00, rs = 8'h00, gs = 8'h00, cseq, tseq, rxs;
    logic [1:0]  rt = 2'b01, ttyp, rxt;
    logic [31:0] wd = 32'h0000_0000, rd, q;
    logic        ack, irq, rdy, ts, tar, tbc, td, re, rar, rbc, cv, cok;
    int          err_total = 0, cmp_count = 0, tx_n = 0, n0 = 0, cyc_n = 0;
    mar_ctrl i_dut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wd), .wb_dat_out(rd),
        .wb_ack_out(ack), .irq_out(irq), .req_valid_in(rv), .req_type_in(rt), .req_seq_in(rs),
        .req_ack_in(ra), .req_bcast_in(rb), .req_indirect_in(ind), .req_ready_out(rdy),
        .fit_in(1'b1), .slot_bound_in(1'b0), .data_req_in(dr), .rx_end_in(re),
        .rx_type_in(rxt), .rx_seq_in(rxs), .rx_ack_req_in(rar), .rx_bcast_in(rbc),
        .tx_start_out(ts), .tx_type_out(ttyp), .tx_seq_out(tseq), .tx_ack_req_out(tar),
        .tx_bcast_out(tbc), .tx_done_in(td), .conf_valid_out(cv), .conf_ok_out(cok),
        .conf_seq_out(cseq));
    mar_peer i_peer (.clk_in(clk_in), .tx_start_in(ts), .tx_seq_in(tseq), .tx_ack_req_in(tar),
        .ack_en_in(ack_en), .rx_go_in(go), .rx_go_seq_in(gs), .tx_done_out(td),
        .rx_end_out(re), .rx_type_out(rxt), .rx_seq_out(rxs), .rx_ack_req_out(rar),
        .rx_bcast_out(rbc));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc_n <= cyc_n + 1;
        if (ts) tx_n <= tx_n + 1;
        if (cyc_n == 20000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        @(posedge clk_in);
        while (ack !== 1'b1) @(posedge clk_in);
        q = rd;
        cyc <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic send(input logic [1:0] t, input logic [7:0] s, input logic a, input logic b);
        n0 = tx_n;
        rv <= 1'b1;
        rt <= t;
        rs <= s;
        ra <= a;
        rb <= b;
        @(posedge clk_in);
        while (rdy !== 1'b1) @(posedge clk_in);
        rv <= 1'b0;
        while (cv !== 1'b1) @(posedge clk_in);
    endtask
    task automatic s_ok();
        wb(1'b0, MAR_CFG_OFS, 32'h0000_0000);
        chk(q, MAR_CFG_RST);
        wb(1'b0, 8'h20, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        // Short wait limit keeps timeouts quick
        wb(1'b1, MAR_WAIT_OFS, 32'h0000_0008);
        wb(1'b1, MAR_CFG_OFS, 32'h0000_0001);
        wb(1'b1, MAR_MASK_OFS, 32'h0000_0001);
        ack_en <= 1'b1;
        send(MAR_FT_DATA, 8'h11, 1'b1, 1'b0);
        chk(tar, 1'b1);
        chk(cok, 1'b1);
        chk(cseq, 8'h11);
        chk(tx_n - n0, 1);
        repeat (2) @(posedge clk_in);
        chk(irq, 1'b1);
        wb(1'b0, MAR_STAT_OFS, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        chk(irq, 1'b0);
    endtask
    task automatic s_fail();
        ack_en <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            send(MAR_FT_CMD, 8'h22, 1'b1, 1'b0);
            chk(cok, 1'b0);
            chk(tx_n - n0, 2);
            chk(tseq, 8'h22);
        end
        wb(1'b0, MAR_STAT_OFS, 32'h0000_0000);
        chk(q, 32'h0000_0002);
    endtask
    task automatic s_noack();
        for (int i = 0; i < 3; i++) begin
            send(i == 0 ? MAR_FT_BEACON : (i == 1 ? MAR_FT_ACK : MAR_FT_DATA), 8'h30, 1'b1, i == 2);
            chk(tar, 1'b0);
            chk(tbc, i == 2);
            chk(cok, 1'b1);
            chk(tx_n - n0, 1);
        end
    endtask
    task automatic s_ind();
        // Short lifetime keeps the queued drop quick
        wb(1'b1, MAR_LIFE_OFS, 32'h0000_0028);
        for (int i = 0; i < 2; i++) begin
            ind <= 1'b1;
            dr <= (i == 1);
            ack_en <= (i == 1);
            send(MAR_FT_DATA, 8'h44, 1'b1, 1'b0);
            chk(cok, i);
            chk(tx_n - n0, i);
        end
        ind <= 1'b0;
        wb(1'b0, MAR_STAT_OFS, 32'h0000_0000);
        chk(q, 32'h0000_000b);
    endtask
    task automatic s_rxack();
        int c;
        for (int i = 0; i < 2; i++) begin
            // No slot bound, so contention mode waits the full backoff
            wb(1'b1, MAR_CFG_OFS, i ? 32'h0000_0011 : 32'h0000_0001);
            go <= 1'b1;
            gs <= 8'h5a;
            @(posedge clk_in);
            go <= 1'b0;
            c = 0;
            while (ts !== 1'b1 && c < 200) begin
                @(posedge clk_in);
                c++;
            end
            chk(tseq, 8'h5a);
            chk(ttyp, MAR_FT_ACK);
            chk(tar, 1'b0);
            chk(c >= (i ? 124 : 44) && c <= (i ? 136 : 56), 1'b1);
            repeat (10) @(posedge clk_in);
        end
        wb(1'b0, MAR_STAT_OFS, 32'h0000_0000);
        chk(q, 32'h0000_0004);
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        s_ok();
        s_fail();
        s_ind();
        s_rxack();
        s_noack();
        results();
    end
endmodule
